// ---- shared/timer_pkg.sv ----
package timer_pkg;

    // register addresses on the 8-bit register port
    localparam logic [7:0] ADDR_CONTROL = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'hE0;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hE1;

    // timer_control_register fields
    localparam int CTL_HIGH_FLAG_BIT = 7;
    localparam int CTL_LOW_FLAG_BIT = 6;
    localparam int CTL_LOW_IRQ_EN_BIT = 5;
    localparam int CTL_CAPTURE_BIT = 4;
    localparam int CTL_SPLIT_BIT = 3;
    localparam int CTL_RUN_BIT = 2;
    localparam int CTL_AUX_MSB = 1;
    localparam int CTL_AUX_LSB = 0;

    // clock_control_register fields
    localparam int CKC_LOW_FAST_BIT = 0;
    localparam int CKC_HIGH_FAST_BIT = 1;

    // ext_irq_enable_register field
    localparam int IRQ_TIMER_EN_BIT = 0;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // auxiliary clock select encodings
    typedef enum logic [1:0] {
        AUX_DIV12_A = 2'b00,
        AUX_EXT_DIV8 = 2'b01,
        AUX_DIV12_B = 2'b10,
        AUX_COMPARATOR = 2'b11
    } aux_clock_t;

    // dividers
    localparam int SYS_DIVIDE = 12;
    localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
    localparam int EXT_DIVIDE = 8;
    localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
    localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;

endpackage : timer_pkg

// ---- verif/testbench.sv ----
`timescale 1ns/1ps

module testbench;
    logic clk_sys;
    logic reset;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic ext_osc_in;
    logic comparator_in;
    logic timer_irq;
    int errors;
    int checks_done;
    int cycles;

    auto_reload_capture_timer i_dut (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .ext_osc_in(ext_osc_in),
        .comparator_in(comparator_in), .timer_irq(timer_irq)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // whole run needs under a thousand cycles; this only catches a hang
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            test_done();
        end
    end

    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // write strobe stays high until the next task lowers it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_read <= 1'b0;
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_write <= 1'b0;
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
        @(posedge clk_sys);
    endtask : rd

    task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp,
        input string name);
        logic [7:0] v;
        rd(a, v);
        check(name, v, exp);
    endtask : expect_reg

    task automatic idle(input int n);
        reg_write <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask : idle

    task automatic irq_is(input logic exp);
        idle(1);
        @(negedge clk_sys);
        check("timer_irq", {7'h00, timer_irq}, {7'h00, exp});
        @(posedge clk_sys);
    endtask : irq_is

    // each pulse is four clocks: two high, two low
    task automatic toggle(input logic ext, input int n);
        reg_write <= 1'b0;
        repeat (n)
        begin
            if (ext) ext_osc_in <= 1'b1;
            else comparator_in <= 1'b1;
            repeat (2) @(posedge clk_sys);
            ext_osc_in <= 1'b0;
            comparator_in <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask : toggle

    task automatic setup(input logic [7:0] ckc, irqe, rll, rlh, cl, ch);
        wr(timer_pkg::ADDR_CLOCK_CONTROL, ckc);
        wr(timer_pkg::ADDR_IRQ_ENABLE, irqe);
        wr(timer_pkg::ADDR_RELOAD_LOW, rll);
        wr(timer_pkg::ADDR_RELOAD_HIGH, rlh);
        wr(timer_pkg::ADDR_COUNT_LOW, cl);
        wr(timer_pkg::ADDR_COUNT_HIGH, ch);
    endtask : setup

    task automatic test_reset_values;
        logic [7:0] addrs [7];
        logic [7:0] v;
        addrs = '{timer_pkg::ADDR_CONTROL, timer_pkg::ADDR_RELOAD_LOW,
            timer_pkg::ADDR_RELOAD_HIGH, timer_pkg::ADDR_COUNT_LOW,
            timer_pkg::ADDR_COUNT_HIGH, timer_pkg::ADDR_CLOCK_CONTROL,
            timer_pkg::ADDR_IRQ_ENABLE};
        foreach (addrs[i])
            expect_reg(addrs[i], 8'h00, "reset value");
        wr(8'h55, 8'hFF);
        expect_reg(8'h55, 8'h00, "unmapped");
        wr(timer_pkg::ADDR_CONTROL, 8'h2B);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h2B, "control");
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
        wr(timer_pkg::ADDR_RELOAD_LOW, 8'h5A);
        expect_reg(timer_pkg::ADDR_RELOAD_LOW, 8'h5A, "reload low");
        wr(timer_pkg::ADDR_CLOCK_CONTROL, 8'h03);
        rd(timer_pkg::ADDR_CLOCK_CONTROL, v);
        check("clock control", v & 8'h03, 8'h03);
    endtask : test_reset_values

    task automatic test_sixteen_bit;
        logic [7:0] a;
        logic [7:0] b;
        setup(8'h01, 8'h01, 8'h00, 8'h12, 8'hF0, 8'hFF);
        expect_reg(timer_pkg::ADDR_COUNT_LOW, 8'hF0, "count low");
        expect_reg(timer_pkg::ADDR_COUNT_HIGH, 8'hFF, "count high");
        irq_is(1'b0);
        wr(timer_pkg::ADDR_CONTROL, 8'h04);
        idle(40);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'hC4, "wrap flags");
        expect_reg(timer_pkg::ADDR_COUNT_HIGH, 8'h12, "reload");
        irq_is(1'b1);
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
        irq_is(1'b0);
        rd(timer_pkg::ADDR_COUNT_LOW, a);
        rd(timer_pkg::ADDR_COUNT_LOW, b);
        check("stopped", b, a);
    endtask : test_sixteen_bit

    task automatic test_low_irq;
        setup(8'h01, 8'h01, 8'h00, 8'h00, 8'hF8, 8'h00);
        wr(timer_pkg::ADDR_CONTROL, 8'h24);
        idle(20);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h64, "low wrap");
        irq_is(1'b1);
        wr(timer_pkg::ADDR_CONTROL, 8'h40);
        irq_is(1'b0);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h40, "flag kept");
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
    endtask : test_low_irq

    task automatic test_split;
        logic [7:0] v;
        setup(8'h03, 8'h01, 8'h80, 8'h80, 8'hFC, 8'hFE);
        wr(timer_pkg::ADDR_CONTROL, 8'h08);
        idle(20);
        expect_reg(timer_pkg::ADDR_COUNT_HIGH, 8'hFE, "high gated");
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h48, "low flag");
        irq_is(1'b0);
        rd(timer_pkg::ADDR_COUNT_LOW, v);
        check("low reload", {7'h00, v[7]}, 8'h01);
        wr(timer_pkg::ADDR_CONTROL, 8'h2C);
        // high byte needs two steps from 0xFE before its flag rises
        idle(4);
        irq_is(1'b1);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'hAC, "high flag");
        rd(timer_pkg::ADDR_COUNT_HIGH, v);
        check("high reload", {4'h0, v[7:4]}, 8'h08);
        wr(timer_pkg::ADDR_CONTROL, 8'h0C);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h0C, "flags cleared");
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
    endtask : test_split

    task automatic test_sources;
        logic [7:0] v;
        setup(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        for (int s = 0; s < 4; s++)
        begin
            wr(timer_pkg::ADDR_COUNT_LOW, 8'h00);
            wr(timer_pkg::ADDR_CONTROL, 8'h04 | 8'(s));
            if (s == 1) toggle(1'b1, 32);
            else if (s == 3) toggle(1'b0, 5);
            else idle(120);
            wr(timer_pkg::ADDR_CONTROL, 8'h00);
            rd(timer_pkg::ADDR_COUNT_LOW, v);
            if (s == 1) check("ext div8", v, 8'h04);
            else if (s == 3) check("comparator", v, 8'h05);
            else check("div12", {7'h00, v inside {9, 10, 11}}, 8'h01);
        end
    endtask : test_sources

    task automatic test_capture;
        logic [7:0] h;
        logic [7:0] l;
        logic [15:0] first;
        setup(8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00);
        wr(timer_pkg::ADDR_CONTROL, 8'h14);
        toggle(1'b0, 1);
        rd(timer_pkg::ADDR_RELOAD_HIGH, h);
        rd(timer_pkg::ADDR_RELOAD_LOW, l);
        first = {h, l} + 16'h003C;
        // second rising edge lands exactly 60 clocks after the first
        idle(52);
        toggle(1'b0, 1);
        rd(timer_pkg::ADDR_RELOAD_HIGH, h);
        rd(timer_pkg::ADDR_RELOAD_LOW, l);
        check("period low", l, first[7:0]);
        check("period high", h, first[15:8]);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h94, "capture flag");
        irq_is(1'b1);
        wr(timer_pkg::ADDR_CONTROL, 8'h16);
        toggle(1'b1, 16);
        expect_reg(timer_pkg::ADDR_CONTROL, 8'h96, "ext capture");
        wr(timer_pkg::ADDR_CONTROL, 8'h00);
        idle(1);
    endtask : test_capture

    initial
    begin
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        ext_osc_in = 1'b0;
        comparator_in = 1'b0;
        errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        test_reset_values();
        test_sixteen_bit();
        test_low_irq();
        test_split();
        test_sources();
        test_capture();
        test_done();
    end
endmodule : testbench

// ---- verif/timer_properties.sv ----
`timescale 1ns/1ps

module timer_properties
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic ext_osc_in,
    input wire logic comparator_in,
    input wire logic timer_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    // mirrors of what software last wrote; the pins alone cannot show them
    logic irq_en_reg;
    logic capture_reg;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            irq_en_reg <= 1'b0;
            capture_reg <= 1'b0;
        end
        else if (reg_write && reg_addr == timer_pkg::ADDR_IRQ_ENABLE)
        begin
            irq_en_reg <= reg_wdata[timer_pkg::IRQ_TIMER_EN_BIT];
        end
        else if (reg_write && reg_addr == timer_pkg::ADDR_CONTROL)
        begin
            capture_reg <= reg_wdata[timer_pkg::CTL_CAPTURE_BIT];
        end
    end

    a_rdata_idle_zero: assert property (
        !reg_read |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_reset_quiet: assert property (
        $past(reset) |-> !timer_irq && reg_rdata == 8'h00)
        else $error("outputs not quiet after reset");
    a_control_readback: assert property (
        reg_write && reg_addr == timer_pkg::ADDR_CONTROL ##1
        reg_read && reg_addr == timer_pkg::ADDR_CONTROL
        |=> (reg_rdata & 8'h3F) == ($past(reg_wdata, 2) & 8'h3F))
        else $error("control fields not read back");
    a_clock_readback: assert property (
        reg_write && reg_addr == timer_pkg::ADDR_CLOCK_CONTROL ##1
        reg_read && reg_addr == timer_pkg::ADDR_CLOCK_CONTROL
        |=> (reg_rdata & 8'h03) == ($past(reg_wdata, 2) & 8'h03))
        else $error("clock selects not read back");
    a_reload_readback: assert property (
        reg_write && reg_addr == timer_pkg::ADDR_RELOAD_LOW && !capture_reg
        ##1 reg_read && reg_addr == timer_pkg::ADDR_RELOAD_LOW
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("reload low not read back");
    a_irq_gated: assert property (
        !irq_en_reg |-> !timer_irq)
        else $error("interrupt while timer interrupt disabled");
    a_irq_sticky: assert property (
        timer_irq && !(reg_write && (reg_addr == timer_pkg::ADDR_CONTROL
        || reg_addr == timer_pkg::ADDR_IRQ_ENABLE)) |=> timer_irq)
        else $error("interrupt dropped without software write");
    a_irq_disable_off: assert property (
        reg_write && reg_addr == timer_pkg::ADDR_IRQ_ENABLE && !reg_wdata[0]
        |=> !timer_irq [*2])
        else $error("interrupt stays after disable");
endmodule : timer_properties

bind auto_reload_capture_timer timer_properties i_props (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_osc_in(ext_osc_in),
    .comparator_in(comparator_in), .timer_irq(timer_irq)
);

// ---- verilog/auto_reload_capture_timer.sv ----
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps

//
// Overview of operation
// - count is sixteen bits formed from separately addressed low and high bytes
// - split select and capture enable both clear run both bytes as one 16-bit auto-reload up-counter
// - 16-bit wrap from all ones loads reload word and sets high flag
// - 16-bit mode with timer interrupt enabled requests interrupt on overflow
// - low-byte wraps also interrupt when low interrupt enable is set too
// - count sources are system clock, clock/12, external/8 and comparator
// - external and comparator inputs are synchronised before use
// - split select set with capture enable clear gives two 8-bit counters, each with own reload byte
// - in split mode run control gates only the high byte
// - each half picks system clock or the auxiliary source by its select bit
// - split mode sets high or low flag when that byte wraps
// - split interrupts on high wrap, or either wrap with low enable set
// - flags are cleared only by software, which checks both flags
// - capture enable set puts the timer into capture mode
// - capture on comparator rise (aux bit1 clear) or every 8th external cycle
// - capture copies count to reload bytes, sets high flag, may interrupt
// - control register resets to zero with the documented field layout
module auto_reload_capture_timer
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic ext_osc_in,
    input wire logic comparator_in,
    output logic timer_irq
);

    logic [7:0] low_count_byte_reg;
    logic [7:0] high_count_byte_reg;
    logic [7:0] reload_low_byte_reg;
    logic [7:0] reload_high_byte_reg;
    logic high_overflow_flag_reg;
    logic low_overflow_flag_reg;
    logic low_overflow_irq_enable_reg;
    logic capture_enable_reg;
    logic split_select_reg;
    logic high_run_control_reg;
    logic [1:0] aux_clock_select_reg;
    logic low_half_fast_select_reg;
    logic high_half_fast_select_reg;
    logic timer_irq_enable_reg;
    logic [7:0] rdata_reg;
    logic [3:0] div12_reg;
    logic [2:0] ext_div_reg;

    logic div12_tick;
    logic ext_rise;
    logic ext_div8_tick;
    logic comp_rise;
    logic aux_tick;
    logic low_tick;
    logic high_tick;
    logic capture_event;
    logic low_step;
    logic high_step;
    logic low_wrap;
    logic high_wrap;
    logic set_high_flag;
    logic set_low_flag;
    logic [15:0] count_word;
    logic [7:0] control_value;

    logic wr_control;
    logic wr_reload_low;
    logic wr_reload_high;
    logic wr_count_low;
    logic wr_count_high;

    assign wr_control = reg_write && reg_addr == timer_pkg::ADDR_CONTROL;
    assign wr_reload_low = reg_write
        && reg_addr == timer_pkg::ADDR_RELOAD_LOW;
    assign wr_reload_high = reg_write
        && reg_addr == timer_pkg::ADDR_RELOAD_HIGH;
    assign wr_count_low = reg_write && reg_addr == timer_pkg::ADDR_COUNT_LOW;
    assign wr_count_high = reg_write
        && reg_addr == timer_pkg::ADDR_COUNT_HIGH;

    assign count_word = {high_count_byte_reg, low_count_byte_reg};

    // external oscillator and comparator enter through two flops
    sync_rise_detect ext_sync
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(ext_osc_in),
        .level_sync(),
        .rise_pulse(ext_rise)
    );

    sync_rise_detect comp_sync
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(comparator_in),
        .level_sync(),
        .rise_pulse(comp_rise)
    );

    // system clock divided by twelve, as a one-cycle enable
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            div12_reg <= 4'h0;
        else if (div12_reg == timer_pkg::SYS_DIV_LAST)
            div12_reg <= 4'h0;
        else
            div12_reg <= div12_reg + 4'h1;
    end

    assign div12_tick = div12_reg == timer_pkg::SYS_DIV_LAST;

    // external oscillator divided by eight, counted on synced rising edges
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            ext_div_reg <= 3'h0;
        else if (ext_rise)
            ext_div_reg <= ext_div_reg + 3'h1;
    end

    assign ext_div8_tick = ext_rise
        && ext_div_reg == timer_pkg::EXT_DIV_LAST;

    always_comb
    begin
        case (timer_pkg::aux_clock_t'(aux_clock_select_reg))
            timer_pkg::AUX_DIV12_A: aux_tick = div12_tick;
            timer_pkg::AUX_EXT_DIV8: aux_tick = ext_div8_tick;
            timer_pkg::AUX_DIV12_B: aux_tick = div12_tick;
            timer_pkg::AUX_COMPARATOR: aux_tick = comp_rise;
            default: aux_tick = 1'b0;
        endcase
    end

    assign low_tick = low_half_fast_select_reg | aux_tick;
    assign high_tick = high_half_fast_select_reg | aux_tick;

    // aux bit 1 picks the capture trigger
    assign capture_event = capture_enable_reg
        && (aux_clock_select_reg[1] ? ext_div8_tick : comp_rise);

    // split mode: low half free-running, high half gated by run control
    always_comb
    begin
        if (split_select_reg && !capture_enable_reg)
        begin
            low_step = low_tick;
            high_step = high_run_control_reg && high_tick;
            low_wrap = low_step
                && low_count_byte_reg == timer_pkg::BYTE_ALL_ONES;
            high_wrap = high_step
                && high_count_byte_reg == timer_pkg::BYTE_ALL_ONES;
        end
        else
        begin
            low_step = high_run_control_reg && low_tick;
            high_step = low_step
                && low_count_byte_reg == timer_pkg::BYTE_ALL_ONES;
            low_wrap = high_step;
            high_wrap = low_step
                && count_word == timer_pkg::WORD_ALL_ONES;
        end
    end

    // capture mode counts freely; only a capture raises the high flag
    assign set_high_flag = capture_enable_reg
        ? capture_event : high_wrap;
    assign set_low_flag = low_wrap;

    // a software write takes priority over a count step on the same byte
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            low_count_byte_reg <= timer_pkg::BYTE_RESET;
        else if (wr_count_low)
            low_count_byte_reg <= reg_wdata;
        else if (low_step)
        begin
            if (low_wrap && split_select_reg && !capture_enable_reg)
                low_count_byte_reg <= reload_low_byte_reg;
            else if (high_wrap && !capture_enable_reg)
                low_count_byte_reg <= reload_low_byte_reg;
            else
                low_count_byte_reg <= low_count_byte_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            high_count_byte_reg <= timer_pkg::BYTE_RESET;
        else if (wr_count_high)
            high_count_byte_reg <= reg_wdata;
        else if (high_step)
        begin
            if (high_wrap && !capture_enable_reg)
                high_count_byte_reg <= reload_high_byte_reg;
            else
                high_count_byte_reg <= high_count_byte_reg + 8'h01;
        end
    end

    // a capture outranks a software write to the reload bytes
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            reload_low_byte_reg <= timer_pkg::BYTE_RESET;
            reload_high_byte_reg <= timer_pkg::BYTE_RESET;
        end
        else if (capture_event)
        begin
            reload_low_byte_reg <= low_count_byte_reg;
            reload_high_byte_reg <= high_count_byte_reg;
        end
        else
        begin
            if (wr_reload_low)
                reload_low_byte_reg <= reg_wdata;
            if (wr_reload_high)
                reload_high_byte_reg <= reg_wdata;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            high_overflow_flag_reg <= 1'b0;
            low_overflow_flag_reg <= 1'b0;
        end
        else
        begin
            high_overflow_flag_reg <= set_high_flag
                | (wr_control ? reg_wdata[timer_pkg::CTL_HIGH_FLAG_BIT]
                              : high_overflow_flag_reg);
            low_overflow_flag_reg <= set_low_flag
                | (wr_control ? reg_wdata[timer_pkg::CTL_LOW_FLAG_BIT]
                              : low_overflow_flag_reg);
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            low_overflow_irq_enable_reg <= timer_pkg::CONTROL_RESET[5];
            capture_enable_reg <= timer_pkg::CONTROL_RESET[4];
            split_select_reg <= timer_pkg::CONTROL_RESET[3];
            high_run_control_reg <= timer_pkg::CONTROL_RESET[2];
            aux_clock_select_reg <= timer_pkg::CONTROL_RESET[1:0];
        end
        else if (wr_control)
        begin
            low_overflow_irq_enable_reg <=
                reg_wdata[timer_pkg::CTL_LOW_IRQ_EN_BIT];
            capture_enable_reg <= reg_wdata[timer_pkg::CTL_CAPTURE_BIT];
            split_select_reg <= reg_wdata[timer_pkg::CTL_SPLIT_BIT];
            high_run_control_reg <= reg_wdata[timer_pkg::CTL_RUN_BIT];
            aux_clock_select_reg <=
                reg_wdata[timer_pkg::CTL_AUX_MSB:timer_pkg::CTL_AUX_LSB];
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            low_half_fast_select_reg <= 1'b0;
            high_half_fast_select_reg <= 1'b0;
            timer_irq_enable_reg <= 1'b0;
        end
        else if (reg_write)
        begin
            if (reg_addr == timer_pkg::ADDR_CLOCK_CONTROL)
            begin
                low_half_fast_select_reg <=
                    reg_wdata[timer_pkg::CKC_LOW_FAST_BIT];
                high_half_fast_select_reg <=
                    reg_wdata[timer_pkg::CKC_HIGH_FAST_BIT];
            end
            if (reg_addr == timer_pkg::ADDR_IRQ_ENABLE)
                timer_irq_enable_reg <= reg_wdata[timer_pkg::IRQ_TIMER_EN_BIT];
        end
    end

    assign control_value = {high_overflow_flag_reg, low_overflow_flag_reg,
        low_overflow_irq_enable_reg, capture_enable_reg, split_select_reg,
        high_run_control_reg, aux_clock_select_reg};

    // read data are registered; unmapped addresses read as zero
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rdata_reg <= 8'h00;
        else if (reg_read)
        begin
            case (reg_addr)
                timer_pkg::ADDR_CONTROL: rdata_reg <= control_value;
                timer_pkg::ADDR_RELOAD_LOW: rdata_reg <= reload_low_byte_reg;
                timer_pkg::ADDR_RELOAD_HIGH: rdata_reg <= reload_high_byte_reg;
                timer_pkg::ADDR_COUNT_LOW: rdata_reg <= low_count_byte_reg;
                timer_pkg::ADDR_COUNT_HIGH: rdata_reg <= high_count_byte_reg;
                timer_pkg::ADDR_CLOCK_CONTROL:
                    rdata_reg <= {6'h00, high_half_fast_select_reg,
                        low_half_fast_select_reg};
                timer_pkg::ADDR_IRQ_ENABLE:
                    rdata_reg <= {7'h00, timer_irq_enable_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata = rdata_reg;

    // level request: held while a flag stands and its enables are set
    assign timer_irq = timer_irq_enable_reg
        && (high_overflow_flag_reg
            || (low_overflow_irq_enable_reg
                && low_overflow_flag_reg));

endmodule : auto_reload_capture_timer

// ---- verilog/sync_rise_detect.sv ----
`timescale 1ns/1ps

// two-flop synchroniser followed by a rising-edge detector
module sync_rise_detect
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic async_in,
    output logic level_sync,
    output logic rise_pulse
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_sync = sync_reg;
    assign rise_pulse = sync_reg & ~last_reg;

endmodule : sync_rise_detect
